/* rtl/adc_device_end.sv */
`timescale 1ns/1ps
`include "adc_link_defines.svh"

module adc_device_end
	import adc_link_pkg::*;
#(
	parameter bit FIXED_DIFF = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	adc_link_if.device link,
	input wire logic [7:0] analog_code,
	output logic awake,
	output logic sampling,
	output logic converting,
	output logic single_ended_select,
	output logic channel_polarity,
	output logic output_order_bit,
	output logic result_done
);

	function automatic logic pick_bit(input logic [7:0] word,
		input logic [3:0] idx);
		pick_bit = word[idx[2:0]];
	endfunction

	localparam logic [2:0] SYNC_INIT = `SYNC_RESET;
	logic [2:0] pin_raw;
	wire [2:0] sync2;
	logic sclk_d;
	wire cs_active;
	wire sclk_s;
	wire din;
	wire rise;
	wire fall;

	device_state_type state;
	device_state_type next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [2:0] cfg;
	logic [2:0] next_cfg;
	logic [7:0] code;
	logic [7:0] next_code;
	logic dout;
	logic next_dout;
	logic dout_oe;
	logic next_oe;
	logic next_samp;
	logic next_conv;
	logic next_done;
	wire lsb_tail;

	assign pin_raw = {link.cs_n, link.sclk, link.dio};

	// Pins come from another timing domain, so two flops each
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			logic stage1;
			logic stage2;
			always_ff @(posedge clk) begin
				if (srst) begin
					stage1 <= SYNC_INIT[gi];
					stage2 <= SYNC_INIT[gi];
				end else if (ce) begin
					stage1 <= pin_raw[gi];
					stage2 <= stage1;
				end
			end
			assign sync2[gi] = stage2;
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_d <= 1'b0;
		end else if (ce) begin
			sclk_d <= sclk_s;
		end
	end

	assign cs_active = ~sync2[2];
	assign sclk_s = sync2[1];
	assign din = sync2[0];
	assign rise = cs_active & sclk_s & ~sclk_d;
	assign fall = cs_active & ~sclk_s & sclk_d;
	// Fixed variant always appends the LSB-first copy
	assign lsb_tail = FIXED_DIFF | ~cfg[`CFG_ORDER_POS];

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_cfg = cfg;
		next_code = code;
		next_dout = dout;
		next_oe = dout_oe;
		next_samp = sampling;
		next_conv = converting;
		next_done = 1'b0;
		if (!cs_active) begin
			// Abort wins over every state, pins are don't-care here
			next_state = ST_SHUTDOWN;
			next_cnt = 4'h0;
			next_oe = 1'b0;
			next_dout = 1'b0;
			next_samp = 1'b0;
			next_conv = 1'b0;
		end else begin
			case (state)
				ST_SHUTDOWN: begin
					next_state = ST_HUNT;
					next_samp = FIXED_DIFF;
				end
				ST_HUNT: begin
					if (rise) begin
						if (FIXED_DIFF) begin
							next_state = ST_ARM;
						end else if (din) begin
							next_state = ST_CONFIG;
							next_cnt = 4'h0;
						end
					end
				end
				ST_CONFIG: begin
					if (rise) begin
						next_cfg = {cfg[1:0], din};
						next_cnt = cnt + 4'h1;
						if (cnt == 4'(`CFG_BITS - 2)) begin
							next_samp = 1'b1;
						end
						if (cnt == 4'(`CFG_BITS - 1)) begin
							next_state = ST_ARM;
						end
					end
				end
				ST_ARM: begin
					if (fall) begin
						// Fourth fall after the start bit (first fall when FIXED_DIFF): null bit goes out
						next_state = ST_MSB;
						next_cnt = 4'h0;
						next_samp = 1'b0;
						next_conv = 1'b1;
						next_oe = 1'b1;
						next_dout = 1'b0;
						next_code = analog_code;
					end
				end
				ST_MSB: begin
					if (fall) begin
						next_dout = pick_bit(code, 4'(`ADC_CODE_W - 1) - cnt);
						next_cnt = cnt + 4'h1;
						if (cnt == 4'(`CONV_CYCLES - 1)) begin
							next_conv = 1'b0;
							next_done = 1'b1;
							next_cnt = 4'h1;
							next_state = lsb_tail ? ST_LSB : ST_ZERO;
						end
					end
				end
				ST_LSB: begin
					if (fall) begin
						// The LSB is shared with the MSB-first run
						next_dout = pick_bit(code, cnt);
						next_cnt = cnt + 4'h1;
						if (cnt == 4'(`ADC_CODE_W - 1)) begin
							next_state = ST_ZERO;
						end
					end
				end
				ST_ZERO: begin
					if (fall) begin
						next_dout = 1'b0;
					end
				end
				default: begin
					next_state = ST_SHUTDOWN;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ST_SHUTDOWN;
			cnt <= 4'h0;
			cfg <= 3'h0;
			code <= 8'h00;
			dout <= 1'b0;
			dout_oe <= 1'b0;
			sampling <= 1'b0;
			converting <= 1'b0;
			result_done <= 1'b0;
			awake <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
			cfg <= next_cfg;
			code <= next_code;
			dout <= next_dout;
			dout_oe <= next_oe;
			sampling <= next_samp;
			converting <= next_conv;
			result_done <= next_done;
			awake <= cs_active;
		end
	end

	assign link.adc_dout = dout;
	assign link.adc_dout_oe = dout_oe;
	assign single_ended_select = cfg[`CFG_SGL_POS];
	assign channel_polarity = cfg[`CFG_POL_POS];
	assign output_order_bit = cfg[`CFG_ORDER_POS];

endmodule // adc_device_end

/* rtl/adc_host_end.sv */
`timescale 1ns/1ps
`include "adc_link_defines.svh"

module adc_host_end
	import adc_link_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	adc_link_if.host link,
	input wire logic start,
	input wire logic single_ended_select,
	input wire logic channel_polarity,
	input wire logic output_order_bit,
	output logic busy,
	output logic [7:0] result,
	output logic result_valid,
	output logic mirror_match
);

	host_state_type state;
	logic cs_n;
	logic sclk;
	logic dio_o;
	logic dio_oe;
	logic [7:0] wake_cnt;
	logic [4:0] div_cnt;
	logic [4:0] rises;
	logic [2:0] tx;
	logic order;
	logic [7:0] rx;
	logic [6:0] mirror;
	logic din_s1;
	logic din_s2;
	wire half_done;
	wire at_rise;
	wire at_fall;
	wire [4:0] last_rise;

	// Divider keeps the serial clock within the converter's limit
	assign half_done = div_cnt == 5'(`SCLK_HALF_CYCLES - 1);
	assign at_rise = (state == H_CLOCK) & half_done & ~sclk;
	assign at_fall = (state == H_CLOCK) & half_done & sclk;
	assign last_rise = order ? 5'(`LAST_MSB_RISE) : 5'(`LAST_MIRROR_RISE);

	always_ff @(posedge clk) begin
		if (srst) begin
			din_s1 <= 1'b1;
			din_s2 <= 1'b1;
		end else if (ce) begin
			din_s1 <= link.dio;
			din_s2 <= din_s1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= H_IDLE;
			cs_n <= 1'b1;
			sclk <= 1'b0;
			dio_o <= 1'b0;
			dio_oe <= 1'b0;
			wake_cnt <= 8'h00;
			div_cnt <= 5'h00;
			rises <= 5'h00;
			tx <= 3'h0;
			order <= 1'b1;
			rx <= 8'h00;
			mirror <= 7'h00;
			busy <= 1'b0;
			result <= 8'h00;
			result_valid <= 1'b0;
			mirror_match <= 1'b0;
		end else if (ce) begin
			result_valid <= 1'b0;
			case (state)
				H_IDLE: begin
					if (start) begin
						tx <= {single_ended_select, channel_polarity,
							output_order_bit};
						order <= output_order_bit;
						cs_n <= 1'b0;
						busy <= 1'b1;
						wake_cnt <= 8'h00;
						state <= H_WAKE;
					end
				end
				H_WAKE: begin
					wake_cnt <= wake_cnt + 8'h01;
					if (wake_cnt == 8'(`WAKEUP_CYCLES - 1)) begin
						dio_o <= 1'b1;
						dio_oe <= 1'b1;
						div_cnt <= 5'h00;
						rises <= 5'h00;
						state <= H_CLOCK;
					end
				end
				H_CLOCK: begin
					div_cnt <= half_done ? 5'h00 : div_cnt + 5'h01;
					if (half_done) begin
						sclk <= ~sclk;
					end
					if (at_rise) begin
						rises <= rises + 5'h01;
						if (rises >= 5'(`FIRST_DATA_RISE) &&
							rises <= 5'(`LAST_MSB_RISE)) begin
							rx <= {rx[6:0], din_s2};
						end else if (rises > 5'(`LAST_MSB_RISE)) begin
							mirror <= {din_s2, mirror[6:1]};
						end
					end
					if (at_fall) begin
						if (rises <= 5'(`ORDER_RISE)) begin
							dio_o <= tx[2];
							tx <= {tx[1:0], 1'b0};
						end
						// Hold the order bit through its rise; the converter
						// sees pins three clocks late, so it drives after this
						if (rises == 5'(`ORDER_RISE + 1)) begin
							dio_oe <= 1'b0;
						end
						if (rises == last_rise + 5'h01) begin
							state <= H_END;
						end
					end
				end
				H_END: begin
					// Raise select at once to cut converter supply time
					cs_n <= 1'b1;
					busy <= 1'b0;
					result <= rx;
					result_valid <= 1'b1;
					mirror_match <= order | (mirror == rx[7:1]);
					state <= H_IDLE;
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	assign link.cs_n = cs_n;
	assign link.sclk = sclk;
	assign link.host_dio = dio_o;
	assign link.host_dio_oe = dio_oe;

endmodule // adc_host_end

/* rtl/adc_link_defines.svh */
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH

// Conversion result and configuration word
`define ADC_CODE_W 8
`define CFG_BITS 3
`define CONV_CYCLES 8

// Field positions inside the three-bit configuration word
`define CFG_SGL_POS 2
`define CFG_POL_POS 1
`define CFG_ORDER_POS 0

// Reset value of the cs_n, sclk, data synchroniser chain
`define SYNC_RESET 3'h4

// Timing, system clock 20 MHz
`define CLK_HZ 20000000
`define WAKEUP_NS 10000
`define WAKEUP_CYCLES ((`WAKEUP_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define SCLK_MAX_HZ 500000
`define SCLK_HALF_CYCLES \
	((`CLK_HZ + 2 * `SCLK_MAX_HZ - 1) / (2 * `SCLK_MAX_HZ))

// Rising-edge indices on the host side, counted from the start bit
`define ORDER_RISE 3
`define FIRST_DATA_RISE 5
`define LAST_MSB_RISE 12
`define LAST_MIRROR_RISE 19

`endif

/* rtl/adc_link_if.sv */
`timescale 1ns/1ps
interface adc_link_if;
	logic cs_n;
	logic sclk;
	logic host_dio;
	logic host_dio_oe;
	logic adc_dout;
	logic adc_dout_oe;
	wire dio;

	// Shared data wire with a weak pull-up when nobody drives it
	assign dio = adc_dout_oe ? adc_dout : (host_dio_oe ? host_dio : 1'b1);

	modport device (
		input cs_n,
		input sclk,
		input dio,
		output adc_dout,
		output adc_dout_oe
	);

	modport host (
		output cs_n,
		output sclk,
		output host_dio,
		output host_dio_oe,
		input dio
	);
endinterface

/* rtl/adc_link_pkg.sv */
package adc_link_pkg;

	typedef enum logic [2:0] {
		ST_SHUTDOWN,
		ST_HUNT,
		ST_CONFIG,
		ST_ARM,
		ST_MSB,
		ST_LSB,
		ST_ZERO
	} device_state_type;

	typedef enum logic [1:0] {
		H_IDLE,
		H_WAKE,
		H_CLOCK,
		H_END
	} host_state_type;

endpackage

/* verif/adc_link_monitor.sv */
`timescale 1ns/1ps
`include "adc_link_defines.svh"
module adc_link_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic host_dio_oe,
	input wire logic adc_dout,
	input wire logic adc_dout_oe
);
	logic [8:0] since_fall;
	logic [2:0] n_fall;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Saturating, so a long frame never wraps under the limits
	always_ff @(posedge clk) begin
		if (cs_n) begin
			since_fall <= 9'h000;
			n_fall <= 3'h0;
		end else begin
			if (since_fall != 9'h1FF) since_fall <= since_fall + 9'h001;
			if ($fell(sclk) && n_fall != 3'h7) n_fall <= n_fall + 3'h1;
		end
	end
	chk_idle_release: assert property (cs_n [*5] |-> !adc_dout_oe)
		else $error("converter drives wire while deselected");
	chk_turnaround_fall: assert property ($rose(adc_dout_oe) |->
		n_fall == 3'h4)
		else $error("turnaround not on fourth fall");
	chk_first_low: assert property ($rose(adc_dout_oe) |->
		!adc_dout && !sclk && $past(sclk, 8))
		else $error("turnaround not low after a fall");
	chk_no_contention: assert property (!(adc_dout_oe && host_dio_oe))
		else $error("both ends drive the wire");
	chk_launch_edge: assert property (adc_dout_oe && $changed(adc_dout)
		|-> !sclk)
		else $error("output bit changed while clock high");
	chk_wake_wait: assert property ($rose(sclk) |->
		since_fall >= `WAKEUP_CYCLES)
		else $error("clock before wake-up interval");
	chk_clock_rate: assert property ($changed(sclk) |=> $stable(sclk) [*8])
		else $error("serial clock too fast");
	chk_idle_quiet: assert property (cs_n |-> !sclk && !host_dio_oe)
		else $error("host active while deselected");
	cover property ($rose(adc_dout_oe));
	cover property ($rose(cs_n) && adc_dout_oe);
	cover property ($fell(cs_n));
endmodule // adc_link_monitor

/* verif/test_serial_adc_port_power_control.sv */
`timescale 1ns/1ps
`include "adc_link_defines.svh"
module test_serial_adc_port_power_control;
	import adc_link_pkg::*;
	logic clk = 0, srst = 1, abort = 0, start = 0, sgl = 0, pol = 0, ord = 0;
	logic [7:0] code = 8'h00;
	logic ce = 1'b1;
	int hold = 0;
	logic [7:0] result;
	logic busy, result_valid, mirror_match, awake, sampling, converting;
	logic dev_sgl, dev_pol, dev_ord, result_done;
	logic [31:0] seed = 32'h0CA65A25;
	int n_errors = 0, tests_run = 0, cycles = 0, n_samp, n_conv, n_done;
	adc_link_if link();
	adc_host_end adc_host_end_inst(.clk(clk), .srst(srst | abort), .ce(ce),
		.link(link), .start(start), .single_ended_select(sgl),
		.channel_polarity(pol), .output_order_bit(ord), .busy(busy),
		.result(result), .result_valid(result_valid),
		.mirror_match(mirror_match));
	adc_device_end adc_device_end_inst(.clk(clk), .srst(srst), .ce(ce),
		.link(link), .analog_code(code), .awake(awake), .sampling(sampling),
		.converting(converting), .single_ended_select(dev_sgl),
		.channel_polarity(dev_pol), .output_order_bit(dev_ord),
		.result_done(result_done));
	// Host reset doubles as the abort path: it raises cs_n without waiting for H_END
	adc_link_monitor adc_link_monitor_inst(.clk(clk), .srst(srst | abort),
		.cs_n(link.cs_n), .sclk(link.sclk), .host_dio_oe(link.host_dio_oe),
		.adc_dout(link.adc_dout), .adc_dout_oe(link.adc_dout_oe));
	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		n_samp += (sampling === 1'b1);
		n_conv += (converting === 1'b1);
		n_done += (result_done === 1'b1);
		if (cycles == 30000) begin
			n_errors++;
			test_done();
		end
	end
	function logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function int exp_samp();
		return 3 * `SCLK_HALF_CYCLES;
	endfunction
	function int exp_conv();
		return 16 * `SCLK_HALF_CYCLES;
	endfunction
	// Cycles from start taken to the result strobe, wake-up included
	function int exp_len(input logic order);
		int last;
		last = order ? `LAST_MSB_RISE : `LAST_MIRROR_RISE;
		return `WAKEUP_CYCLES + 2 * `SCLK_HALF_CYCLES * (last + 1) + 1;
	endfunction
	task check8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task checkn(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			n_errors++;
			$display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask
	task launch(input logic [10:0] v);
		@(posedge clk);
		#2 {sgl, pol, ord, code} = v;
		start = 1;
		n_samp = 0;
		n_conv = 0;
		n_done = 0;
		@(posedge clk);
		#2 start = 0;
	endtask
	task frame(input logic [10:0] v);
		int t0;
		launch(v);
		t0 = cycles;
		// Freeze both ends while the serial clock is high
		if (hold > 0) begin
			repeat (230) @(posedge clk);
			#2 ce = 0;
			repeat (hold) @(posedge clk);
			#1 check8({5'h00, busy, link.sclk, awake}, 8'h07);
			#1 ce = 1;
		end
		while (result_valid !== 1'b1 && cycles - t0 < 3000) begin
			@(posedge clk);
			#1;
		end
		checkn(cycles - t0, exp_len(ord) + hold);
		check8({6'h00, busy, awake}, 8'h01);
		check8(result, code);
		check8({7'h00, mirror_match}, 8'h01);
		check8({5'h00, dev_sgl, dev_pol, dev_ord}, {5'h00, sgl, pol, ord});
		checkn(n_samp, exp_samp());
		checkn(n_conv, exp_conv());
		checkn(n_done, 1);
		repeat (10) @(posedge clk);
		#1 check8({7'h00, awake}, 8'h00);
	endtask
	task test_done();
		if (n_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#2 srst = 0;
		frame(11'h700);
		frame(11'h6FF);
		frame(11'h1FF);
		frame(11'h000);
		hold = 50;
		frame(11'h2A5);
		hold = 0;
		repeat (6) begin
			seed = lfsr(seed);
			frame(seed[10:0]);
		end
		// Abort while the converter is shifting out its result
		seed = lfsr(seed);
		launch(seed[10:0]);
		repeat (700) @(posedge clk);
		#2 abort = 1;
		repeat (2) @(posedge clk);
		#2 abort = 0;
		repeat (10) @(posedge clk);
		#1;
		check8({7'h00, link.adc_dout_oe}, 8'h00);
		check8({7'h00, awake}, 8'h00);
		seed = lfsr(seed);
		frame(seed[10:0]);
		test_done();
	end
endmodule // test_serial_adc_port_power_control
